// file: core/dctd_cfg.svh
// constants for the duty cycle temperature decoder
`ifndef DCTD_CFG_SVH
`define DCTD_CFG_SVH

// register byte addresses on the axi4-lite slave
`define DCTD_ADDR_CTRL 8'h00
`define DCTD_ADDR_STATUS 8'h04
`define DCTD_ADDR_IRQ_CLR 8'h08
`define DCTD_ADDR_IRQ_EN 8'h0C
`define DCTD_ADDR_HIGH 8'h10
`define DCTD_ADDR_LOW 8'h14
`define DCTD_ADDR_BYTES 8'h18
`define DCTD_ADDR_TEMP 8'h1C
`define DCTD_ADDR_CAL 8'h20

// control register fields
`define DCTD_CTRL_START 0
`define DCTD_CTRL_CONT 1
`define DCTD_CTRL_CLEAR 2

// status and interrupt bits
`define DCTD_ST_DONE 0
`define DCTD_ST_ERR 1
`define DCTD_ST_BUSY 2
`define DCTD_NUM_IRQ 2

// counting timebase
`define DCTD_CLK_HZ 50000000
`define DCTD_CNT_DIV 12
`define DCTD_DIV_MAX 4'h0B
`define DCTD_CNT_W 16
`define DCTD_MODE_16BIT 8'h11
`define DCTD_CNT_FULL 16'hFFFF

// longest legal phase: 32 ms
`define DCTD_PHASE_MAX_MS 32
`define DCTD_PHASE_MAX_CNT \
	((`DCTD_CLK_HZ / `DCTD_CNT_DIV / 1000) * `DCTD_PHASE_MAX_MS)

// conversion constants: temp = offset - slope * high / low
`define DCTD_OFFSET_DEF 16'h00EB
`define DCTD_SLOPE_DEF 16'h0190
`define DCTD_QUO_W 32
`endif

// file: core/dctd_pkg.sv
// types for the duty cycle temperature decoder
package dctd_pkg;
	typedef enum logic [2:0] {
		DCTD_IDLE,
		DCTD_WAIT_LOW,
		DCTD_WAIT_RISE,
		DCTD_HIGH,
		DCTD_LOW,
		DCTD_CALC
	} dctd_state_t;
endpackage : dctd_pkg

// file: core/dctd_div.sv
// serial unsigned divider for the ratio computation
`timescale 1ns/1ps
`include "dctd_cfg.svh"
module dctd_div
	import dctd_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// request
	input wire logic start,
	input wire logic [`DCTD_QUO_W-1:0] dividend,
	input wire logic [`DCTD_CNT_W-1:0] divisor,
	// answer
	output logic done,
	output logic [`DCTD_QUO_W-1:0] quotient
);
	logic [`DCTD_QUO_W-1:0] quo_reg;
	logic [`DCTD_CNT_W:0] rem_reg;
	logic [5:0] step_reg;
	logic busy_reg;
	logic [`DCTD_CNT_W:0] trial;

	assign trial = {rem_reg[`DCTD_CNT_W-1:0], quo_reg[`DCTD_QUO_W-1]}
		- {1'b0, divisor};

	// one quotient bit per clock, restoring style, 32 cycles total
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			quo_reg <= 32'h0000_0000;
			rem_reg <= 17'h0_0000;
			step_reg <= 6'h00;
			busy_reg <= 1'b0;
			done <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			if (start)
			begin
				quo_reg <= dividend;
				rem_reg <= 17'h0_0000;
				step_reg <= 6'h00;
				busy_reg <= 1'b1;
			end
			else if (busy_reg)
			begin
				if (!trial[`DCTD_CNT_W])
				begin
					rem_reg <= trial;
					quo_reg <= {quo_reg[`DCTD_QUO_W-2:0], 1'b1};
				end
				else
				begin
					rem_reg <= {rem_reg[`DCTD_CNT_W-1:0],
						quo_reg[`DCTD_QUO_W-1]};
					quo_reg <= {quo_reg[`DCTD_QUO_W-2:0], 1'b0};
				end
				step_reg <= step_reg + 6'h01;
				if (step_reg == 6'(`DCTD_QUO_W - 1))
				begin
					busy_reg <= 1'b0;
					done <= 1'b1;
				end
			end
		end
	end

	assign quotient = quo_reg;
endmodule : dctd_div

// file: core/dctd_top.sv
// duty cycle temperature decoder with axi4-lite register slave
`timescale 1ns/1ps
`include "dctd_cfg.svh"
module dctd_top
	import dctd_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// sensor line
	input wire logic sensor_in,
	// axi4-lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// interrupt
	output logic irq
);
	dctd_state_t state_reg;
	logic sync1_reg, sync2_reg, prev_reg;
	logic rise, fall;
	logic [3:0] div_reg;
	logic tick;
	logic [7:0] counter_mode_setting_reg;
	logic [1:0] counter_run_control_reg;
	logic [`DCTD_CNT_W-1:0] high_phase_time_reg;
	logic [`DCTD_CNT_W-1:0] low_phase_time_reg;
	logic [`DCTD_CNT_W-1:0] cnt_reg [2];
	logic [1:0] run_en;
	logic [1:0] ovf_reg;
	logic cont_reg;
	logic [`DCTD_NUM_IRQ-1:0] status_reg, irq_en_reg, evt;
	logic [15:0] offset_reg, slope_reg, temp_reg;
	logic div_start_reg, div_done;
	logic [`DCTD_QUO_W-1:0] quotient;
	logic [`DCTD_QUO_W-1:0] dividend;
	logic aw_got_reg, w_got_reg;
	logic [7:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic wr_fire;
	logic start_cmd, clear_cmd;
	logic [`DCTD_NUM_IRQ-1:0] clr_bits;

	// two-flop synchroniser; only the second flop feeds the edge detector
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			prev_reg <= 1'b0;
		end
		else
		begin
			sync1_reg <= sensor_in;
			sync2_reg <= sync1_reg;
			prev_reg <= sync2_reg;
		end
	end
	// both edges see the same two-flop delay, so no phase is skewed
	assign rise = sync2_reg & ~prev_reg;
	assign fall = ~sync2_reg & prev_reg;

	// timebase: clock divided by 12; frequency accuracy is irrelevant
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			div_reg <= 4'h0;
		else if (div_reg == `DCTD_DIV_MAX)
			div_reg <= 4'h0;
		else
			div_reg <= div_reg + 4'h1;
	end
	assign tick = (div_reg == `DCTD_DIV_MAX);

	// counter enables need mode and run control together
	generate
		for (genvar i = 0; i < 2; i++)
		begin : g_cnt
			assign run_en[i] = counter_run_control_reg[i] &
				(counter_mode_setting_reg == `DCTD_MODE_16BIT);
			always_ff @(posedge ref_clk or negedge nrst)
			begin
				if (!nrst)
				begin
					cnt_reg[i] <= 16'h0000;
					ovf_reg[i] <= 1'b0;
				end
				else if (state_reg == DCTD_IDLE && start_cmd)
				begin
					cnt_reg[i] <= 16'h0000;
					ovf_reg[i] <= 1'b0;
				end
				else if (run_en[i] && tick)
				begin
					// saturate rather than wrap, so a dead line reads full
					if (cnt_reg[i] != `DCTD_CNT_FULL)
						cnt_reg[i] <= cnt_reg[i] + 16'h0001;
					// 32 ms lies past the 16-bit range: a full count is over
					if (32'(cnt_reg[i]) >= 32'(`DCTD_PHASE_MAX_CNT) ||
						cnt_reg[i] == `DCTD_CNT_FULL)
						ovf_reg[i] <= 1'b1;
				end
			end
		end
	endgenerate

	// sequencer: wait low, arm on rise, time high, time low
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_reg <= DCTD_IDLE;
			counter_mode_setting_reg <= 8'h00;
			counter_run_control_reg <= 2'b00;
			div_start_reg <= 1'b0;
		end
		else
		begin
			div_start_reg <= 1'b0;
			case (state_reg)
				DCTD_IDLE:
				begin
					if (start_cmd)
					begin
						counter_mode_setting_reg <= `DCTD_MODE_16BIT;
						state_reg <= DCTD_WAIT_LOW;
					end
				end
				DCTD_WAIT_LOW:
				begin
					if (!sync2_reg)
						state_reg <= DCTD_WAIT_RISE;
				end
				DCTD_WAIT_RISE:
				begin
					if (rise)
					begin
						counter_run_control_reg <= 2'b01;
						state_reg <= DCTD_HIGH;
					end
				end
				DCTD_HIGH:
				begin
					if (fall || ovf_reg[0])
					begin
						counter_run_control_reg <= 2'b10;
						state_reg <= DCTD_LOW;
					end
				end
				DCTD_LOW:
				begin
					if (rise || ovf_reg[1])
					begin
						counter_run_control_reg <= 2'b00;
						counter_mode_setting_reg <= 8'h00;
						div_start_reg <= 1'b1;
						state_reg <= DCTD_CALC;
					end
				end
				DCTD_CALC:
				begin
					if (div_done)
						state_reg <= DCTD_IDLE;
				end
				default:
					state_reg <= DCTD_IDLE;
			endcase
		end
	end

	// slope*high/low; a zero low count is passed to the divider as one
	assign dividend = 32'(slope_reg) * 32'(cnt_reg[0]);
	dctd_div u_div (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.start(div_start_reg),
		.dividend(dividend),
		.divisor((cnt_reg[1] == 16'h0000) ? 16'h0001 : cnt_reg[1]),
		.done(div_done),
		.quotient(quotient)
	);

	// results latched on completion and held until clear or restart
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			high_phase_time_reg <= 16'h0000;
			low_phase_time_reg <= 16'h0000;
			temp_reg <= 16'h0000;
		end
		else if (clear_cmd || (state_reg == DCTD_IDLE && start_cmd))
		begin
			high_phase_time_reg <= 16'h0000;
			low_phase_time_reg <= 16'h0000;
			temp_reg <= 16'h0000;
		end
		else if (div_done)
		begin
			high_phase_time_reg <= cnt_reg[0];
			low_phase_time_reg <= cnt_reg[1];
			temp_reg <= offset_reg - quotient[15:0];
		end
	end

	// sticky events; a new event wins over a same-cycle clear
	assign evt[`DCTD_ST_DONE] = div_done;
	assign evt[`DCTD_ST_ERR] = div_done & (|ovf_reg);
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			status_reg <= 2'b00;
		else
			status_reg <= (status_reg & ~clr_bits) | evt;
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			irq <= 1'b0;
		else
			irq <= |((status_reg | evt) & irq_en_reg);
	end

	// axi4-lite write path: address and data accepted in either order
	assign wr_fire = aw_got_reg & w_got_reg & ~s_axi_bvalid;
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h0000_0000;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end
		else
		begin
			s_axi_awready <= ~aw_got_reg & ~s_axi_awready & s_axi_awvalid
				& ~s_axi_bvalid;
			s_axi_wready <= ~w_got_reg & ~s_axi_wready & s_axi_wvalid
				& ~s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_got_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_got_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
			end
			if (wr_fire)
			begin
				aw_got_reg <= 1'b0;
				w_got_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				case (aw_addr_reg)
					`DCTD_ADDR_CTRL, `DCTD_ADDR_IRQ_CLR,
					`DCTD_ADDR_IRQ_EN, `DCTD_ADDR_CAL:
						s_axi_bresp <= 2'b00;
					default:
						s_axi_bresp <= 2'b10;
				endcase
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	assign start_cmd = wr_fire && aw_addr_reg == `DCTD_ADDR_CTRL &&
		w_data_reg[`DCTD_CTRL_START];
	assign clear_cmd = wr_fire && aw_addr_reg == `DCTD_ADDR_CTRL &&
		w_data_reg[`DCTD_CTRL_CLEAR];
	assign clr_bits = (wr_fire && aw_addr_reg == `DCTD_ADDR_IRQ_CLR) ?
		w_data_reg[`DCTD_NUM_IRQ-1:0] : 2'b00;

	// writable configuration, byte strobes ignored: whole-word writes only
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			cont_reg <= 1'b0;
			irq_en_reg <= 2'b00;
			offset_reg <= `DCTD_OFFSET_DEF;
			slope_reg <= `DCTD_SLOPE_DEF;
		end
		else if (wr_fire)
		begin
			case (aw_addr_reg)
				`DCTD_ADDR_CTRL:
					cont_reg <= w_data_reg[`DCTD_CTRL_CONT];
				`DCTD_ADDR_IRQ_EN:
					irq_en_reg <= w_data_reg[`DCTD_NUM_IRQ-1:0];
				`DCTD_ADDR_CAL:
				begin
					offset_reg <= w_data_reg[15:0];
					slope_reg <= w_data_reg[31:16];
				end
				default:
					cont_reg <= cont_reg;
			endcase
		end
	end

	// axi4-lite read path, one cycle from address accept to rvalid
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'b00;
		end
		else
		begin
			s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'b00;
				case (s_axi_araddr)
					`DCTD_ADDR_CTRL:
						s_axi_rdata <= {30'h0000_0000, cont_reg, 1'b0};
					`DCTD_ADDR_STATUS:
						s_axi_rdata <= {29'h0000_0000,
							state_reg != DCTD_IDLE, status_reg};
					`DCTD_ADDR_IRQ_EN:
						s_axi_rdata <= {30'h0000_0000, irq_en_reg};
					`DCTD_ADDR_HIGH:
						s_axi_rdata <= {16'h0000, high_phase_time_reg};
					`DCTD_ADDR_LOW:
						s_axi_rdata <= {16'h0000, low_phase_time_reg};
					`DCTD_ADDR_BYTES:
						s_axi_rdata <= {low_phase_time_reg[15:8],
							high_phase_time_reg[15:8],
							low_phase_time_reg[7:0],
							high_phase_time_reg[7:0]};
					`DCTD_ADDR_TEMP:
						s_axi_rdata <= {16'h0000, temp_reg};
					`DCTD_ADDR_CAL:
						s_axi_rdata <= {slope_reg, offset_reg};
					default:
					begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= 2'b10;
					end
				endcase
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end
endmodule : dctd_top

// file: bench/dctd_sensor.sv
// behavioural model of the pulse-width temperature sensor
`timescale 1ns/1ps
module dctd_sensor (
	// phase lengths in reference clock periods
	input wire logic [15:0] t_high,
	input wire logic [15:0] t_low,
	// the single sensor line
	output logic sensor_in
);
	int h;
	int l;
	initial
	begin
		sensor_in = 1'b0;
		#5;
		forever
		begin
			// lengths latch at the rise so a period is never mixed
			h = t_high;
			l = t_low;
			// one timebase for both phases: no skew between them
			sensor_in = 1'b1;
			#(h * 20);
			sensor_in = 1'b0;
			#(l * 20);
		end
	end
endmodule : dctd_sensor

// file: bench/dctd_checker.sv
// bus handshake assertions for the temperature decoder
`timescale 1ns/1ps
module dctd_checker (
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// write side
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// read side
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	chk_b_hold: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped early");
	chk_r_hold: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped early");
	chk_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("write address ready not a pulse");
	chk_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready)
		else $error("read address ready not a pulse");
	chk_r_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	chk_b_answer: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:2] s_axi_bvalid) else $error("write answer late");
	chk_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	chk_aw_busy: assert property (
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answer pending");
endmodule : dctd_checker

bind dctd_top dctd_checker u_chk (.ref_clk, .nrst, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rvalid, .s_axi_rready);

// file: bench/testbench.sv
// self-checking bench for the duty cycle temperature decoder
`timescale 1ns/1ps
`include "dctd_cfg.svh"
module testbench;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic sensor_in;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_awready;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_wready;
	logic [1:0] s_axi_bresp;
	logic s_axi_bvalid;
	logic s_axi_bready = 1'b0;
	logic [7:0] s_axi_araddr = 8'h00;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0] s_axi_rresp;
	logic s_axi_rvalid;
	logic s_axi_rready = 1'b0;
	logic irq;
	logic [15:0] t_high = 16'd600;
	logic [15:0] t_low = 16'd1200;
	int n_mismatch = 0;
	int samples_checked = 0;
	int seed = 245;
	logic [31:0] d;
	logic [1:0] r;

	always #10 ref_clk = ~ref_clk;

	dctd_top u_dut (.ref_clk, .nrst, .sensor_in, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);
	dctd_sensor u_sensor (.t_high, .t_low, .sensor_in);

	task automatic results;
		if (n_mismatch == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : results

	task automatic chk(input string what, input logic [31:0] e, g);
		samples_checked++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, e, g);
		end
	endtask : chk

	// the line is asynchronous, so a count may land one tick either way
	task automatic near(input string what, input int e, input logic [31:0] g);
		samples_checked++;
		if ($isunknown(g) || g > e + 1 || g + 1 < e)
		begin
			n_mismatch++;
			$display("wrong value %s expected %0d seen %0d", what, e, g);
		end
	endtask : near

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		bit pa;
		bit pw;
		pa = 1;
		pw = 1;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (pa || pw)
		begin
			@(posedge ref_clk);
			if (pa && s_axi_awready === 1'b1)
			begin
				s_axi_awvalid <= 1'b0;
				pa = 0;
			end
			if (pw && s_axi_wready === 1'b1)
			begin
				s_axi_wvalid <= 1'b0;
				pw = 0;
			end
		end
		s_axi_bready <= 1'b1;
		do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b1;
		do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd

	task automatic measure(input int i);
		logic [31:0] h;
		logic [31:0] l;
		logic [31:0] t;
		logic [15:0] off;
		logic [15:0] slope;
		int k;
		if (i > 0)
		begin
			// both phases stay far below 32 ms
			t_high <= 16'd240 + 16'({$random(seed)} % 960);
			t_low <= 16'd480 + 16'({$random(seed)} % 1920);
		end
		off = (i == 3) ? 16'h0064 : `DCTD_OFFSET_DEF;
		slope = (i == 3) ? 16'h0100 : `DCTD_SLOPE_DEF;
		wr(`DCTD_ADDR_CAL, {slope, off});
		wr(`DCTD_ADDR_IRQ_EN, {31'h0, i[0]});
		@(posedge sensor_in);
		@(posedge ref_clk);
		wr(`DCTD_ADDR_CTRL, 32'h0000_0001);
		rd(`DCTD_ADDR_STATUS);
		chk("busy", 32'h1, {31'h0, d[2]});
		k = 0;
		do
		begin
			rd(`DCTD_ADDR_STATUS);
			k++;
		end
		while (d[0] !== 1'b1 && k < 3000);
		chk("done", 32'h1, {31'h0, d[0]});
		chk("error", 32'h0, {31'h0, d[1]});
		chk("idle", 32'h0, {31'h0, d[2]});
		chk("irq", {31'h0, i[0]}, {31'h0, irq});
		rd(`DCTD_ADDR_HIGH);
		h = d;
		near("high count", t_high / 12, h);
		rd(`DCTD_ADDR_LOW);
		l = d;
		near("low count", t_low / 12, l);
		rd(`DCTD_ADDR_BYTES);
		chk("bytes", {l[15:8], h[15:8], l[7:0], h[7:0]}, d);
		rd(`DCTD_ADDR_TEMP);
		t = off - slope * h / l;
		chk("temp", {16'h0, t[15:0]}, {16'h0, d[15:0]});
		wr(`DCTD_ADDR_IRQ_CLR, 32'h0000_0003);
		@(posedge ref_clk);
		chk("irq clear", 32'h0, {31'h0, irq});
		rd(`DCTD_ADDR_HIGH);
		chk("high held", h, d);
		wr(`DCTD_ADDR_CTRL, 32'h0000_0004);
		rd(`DCTD_ADDR_HIGH);
		chk("high cleared", 32'h0, d);
	endtask : measure

	initial
	begin
		repeat (95000) @(posedge ref_clk);
		n_mismatch++;
		results;
	end

	initial
	begin
		repeat (3) @(posedge ref_clk);
		nrst <= 1'b1;
		@(posedge ref_clk);
		rd(`DCTD_ADDR_IRQ_EN);
		chk("irq enable reset", 32'h0, d);
		rd(`DCTD_ADDR_CAL);
		chk("cal reset", 32'h0190_00EB, d);
		rd(8'h3C);
		chk("unmapped resp", 32'h2, {30'h0, r});
		chk("unmapped data", 32'h0, d);
		wr(`DCTD_ADDR_STATUS, 32'h0000_0001);
		chk("read-only resp", 32'h2, {30'h0, r});
		for (int i = 0; i < 5; i++)
			measure(i);
		results;
	end
endmodule : testbench
